// [core/tqb_pkg.sv]
// package: constants, register map and types for the trigger qualifier and burst block
package tqb_pkg;
    // clock
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 40;
    // times as printed, in nanoseconds
    localparam longint unsigned MIN_W_DEF_NS  = 64'd100_000_000;  // 100e-3 s
    localparam longint unsigned MAX_W_DEF_NS  = 64'd1_000_000;    // 1e-3 s
    localparam longint unsigned HOLD_DEF_NS   = 64'd10;           // 10e-9 s
    localparam longint unsigned TIME_MAX_NS   = 64'd2_000_000_000; // 2 s
    // cycle counts: least times round up, never below one
    localparam int unsigned MIN_W_DEF_CYC =
        int'((MIN_W_DEF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int unsigned MAX_W_DEF_CYC = int'(MAX_W_DEF_NS / CLK_PERIOD_NS);
    localparam int unsigned HOLD_DEF_CYC  =
        (HOLD_DEF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
        int'((HOLD_DEF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int unsigned CNT_W = 26;   // holds 2 s of 40 ns cycles
    localparam int unsigned BURST_W = 25; // holds 16,777,216
    localparam int unsigned DELAY_W = 23; // holds 8e6
    localparam logic [BURST_W-1:0] BURST_DEF = 25'h0000001;
    localparam logic [DELAY_W-1:0] DELAY_MAX = 23'h7a1200;
    localparam logic [BURST_W-1:0] BURST_MAX = 25'h1000000;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_BURST  = 8'h04;
    localparam logic [7:0] OFS_DELAY  = 8'h08;
    localparam logic [7:0] OFS_MINW   = 8'h0c;
    localparam logic [7:0] OFS_MAXW   = 8'h10;
    localparam logic [7:0] OFS_HOLD   = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_CMD    = 8'h1c;
    // ctrl bits
    localparam int unsigned CB_CONT = 0;
    localparam int unsigned CB_MINON = 1;
    localparam int unsigned CB_MAXON = 2;
    localparam int unsigned CB_HOLDON = 3;
    localparam int unsigned CB_SLOPE = 4;   // two bits
    localparam int unsigned CB_SRC = 6;     // two bits
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam int unsigned CMD_TRIG = 0;
    typedef enum logic [1:0] {SLOPE_POS, SLOPE_NEG, SLOPE_EITHER} tqb_slope_type;
    typedef enum logic [1:0] {SRC_EXT, SRC_BUS, SRC_MANUAL} tqb_src_type;
    typedef struct packed {
        logic                    cont;
        logic                    min_width_filter_on;
        logic                    max_width_filter_on;
        logic                    holdoff_on;
        tqb_slope_type           slope;
        tqb_src_type             src;
        logic [BURST_W-1:0]      burst;
        logic [DELAY_W-1:0]      delay;
        logic [CNT_W-1:0]        min_pulse_width;
        logic [CNT_W-1:0]        max_pulse_width;
        logic [CNT_W-1:0]        holdoff;
    } tqb_cfg_type;
    function automatic logic [CNT_W-1:0] tqb_sat_cnt(input logic [31:0] v);
        return (v > 32'(TIME_MAX_NS / CLK_PERIOD_NS)) ?
            CNT_W'(TIME_MAX_NS / CLK_PERIOD_NS) : v[CNT_W-1:0];
    endfunction
endpackage

// [core/tqb_width_filter.sv]
// pulse width measurement and min/max/window qualification of the trigger line
`timescale 1ns/1ns
`default_nettype none
module tqb_width_filter import tqb_pkg::*; (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             trig_i,
    input  wire tqb_cfg_type      cfg_i,
    output logic                  valid_o
);
    typedef struct packed {
        logic             prev;
        logic [CNT_W-1:0] width;
        logic             valid;
    } tqb_wf_state_type;
    tqb_wf_state_type st_r, st_nxt;
    logic active, start_edge, end_edge, pass;
    always_comb begin
        st_nxt = st_r;
        st_nxt.valid = 1'b0;
        st_nxt.prev = trig_i;
        // active level is the one entered by the selected edge
        active = (cfg_i.slope == SLOPE_NEG) ? ~trig_i : trig_i;
        start_edge = (cfg_i.slope == SLOPE_NEG) ? (st_r.prev & ~trig_i) : (~st_r.prev & trig_i);
        end_edge = (cfg_i.slope == SLOPE_NEG) ? (~st_r.prev & trig_i) : (st_r.prev & ~trig_i);
        pass = 1'b1;
        if (cfg_i.min_width_filter_on && !(st_r.width > cfg_i.min_pulse_width)) begin
            pass = 1'b0;
        end
        if (cfg_i.max_width_filter_on && !(st_r.width < cfg_i.max_pulse_width)) begin
            pass = 1'b0;
        end
        if (start_edge) begin
            st_nxt.width = CNT_W'(1);
        end else if (active && st_r.width != '1) begin
            st_nxt.width = st_r.width + CNT_W'(1);
        end
        // width known only at the trailing edge; unfiltered either-slope fires on every edge
        if (cfg_i.slope == SLOPE_EITHER && !cfg_i.min_width_filter_on &&
            !cfg_i.max_width_filter_on) begin
            st_nxt.valid = st_r.prev ^ trig_i;
        end else if (!cfg_i.min_width_filter_on && !cfg_i.max_width_filter_on) begin
            st_nxt.valid = start_edge;
        end else begin
            st_nxt.valid = end_edge & pass;
        end
        if (!rst_n_i) begin
            st_nxt = '0;
        end
    end
    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end
    assign valid_o = st_r.valid;
endmodule // tqb_width_filter
`default_nettype wire

// [core/tqb_holdoff.sv]
// holdoff window: ignores line triggers for a programmed time after a valid one
`timescale 1ns/1ns
`default_nettype none
module tqb_holdoff import tqb_pkg::*; (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             valid_i,
    input  wire tqb_cfg_type      cfg_i,
    output logic                  pass_o
);
    typedef struct packed {
        logic [CNT_W-1:0] left;
    } tqb_ho_state_type;
    tqb_ho_state_type st_r, st_nxt;
    always_comb begin
        st_nxt = st_r;
        pass_o = valid_i && (!cfg_i.holdoff_on || st_r.left == '0);
        if (st_r.left != '0) begin
            st_nxt.left = st_r.left - CNT_W'(1);
        end
        if (pass_o && cfg_i.holdoff_on) begin
            st_nxt.left = cfg_i.holdoff;
        end
        if (!rst_n_i || !cfg_i.holdoff_on) begin
            st_nxt = '0;
        end
    end
    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end
endmodule // tqb_holdoff
`default_nettype wire

// [core/tqb_top.sv]
// trigger qualifier and burst controller with apb register access
// Functional notes
// - accepted trigger yields exactly burst-count cycles, default one
// - manual button, remote command or input transition trigger
// - burst and delay apply only in triggered mode
// - wait programmed delay in sample clocks before output
// - delay 0 to 8e6, zero means none
// - min filter rejects pulses not wider than minimum
// - max filter rejects pulses not narrower than maximum
// - both filters on form a width window
// - min filter switch, off after reset
// - max filter switch, off after reset
// - holdoff ignores all triggers within window; code holds off line triggers only, button and command bypass it
// - holdoff programmable, default ten nanoseconds; code rounds it up to one 40 ns clock
// - holdoff switch, off after reset
// - clearing continuous selects triggered mode
// - further triggers ignored while burst runs
`timescale 1ns/1ns
`default_nettype none
module tqb_top import tqb_pkg::*; (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             psel_i,
    input  wire logic             penable_i,
    input  wire logic             pwrite_i,
    input  wire logic [7:0]       paddr_i,
    input  wire logic [31:0]      pwdata_i,
    output logic [31:0]           prdata_o,
    output logic                  pready_o,
    output logic                  pslverr_o,
    input  wire logic             trig_in_i,
    input  wire logic             manual_btn_i,
    input  wire logic             cycle_done_i,
    output logic                  burst_start_o,
    output logic                  running_o,
    output logic                  idle_return_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_BURST} tqb_fsm_type;
    typedef struct packed {
        tqb_cfg_type        cfg;
        tqb_fsm_type        fsm;
        logic [DELAY_W-1:0] dcnt;
        logic [BURST_W-1:0] bcnt;
        logic               bus_trig;
        logic               btn_prev;
        logic [31:0]        prdata;
        logic               pready;
        logic               pslverr;
        logic               start;
        logic               idle_ret;
        logic [BURST_W-1:0] accepted;
        logic               running;
    } tqb_state_type;
    tqb_state_type st_r, st_nxt;
    logic ext_valid, ext_pass, trig_evt, wr_acc, rd_acc;
    tqb_width_filter u_wf (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .trig_i  (trig_in_i),
        .cfg_i   (st_r.cfg),
        .valid_o (ext_valid)
    );
    tqb_holdoff u_ho (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .valid_i (ext_valid),
        .cfg_i   (st_r.cfg),
        .pass_o  (ext_pass)
    );
    function automatic logic [31:0] rd_mux(input tqb_state_type s, input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            OFS_CTRL: begin
                v[CB_CONT] = s.cfg.cont;
                v[CB_MINON] = s.cfg.min_width_filter_on;
                v[CB_MAXON] = s.cfg.max_width_filter_on;
                v[CB_HOLDON] = s.cfg.holdoff_on;
                v[CB_SLOPE +: 2] = s.cfg.slope;
                v[CB_SRC +: 2] = s.cfg.src;
            end
            OFS_BURST: v = 32'(s.cfg.burst);
            OFS_DELAY: v = 32'(s.cfg.delay);
            OFS_MINW: v = 32'(s.cfg.min_pulse_width);
            OFS_MAXW: v = 32'(s.cfg.max_pulse_width);
            OFS_HOLD: v = 32'(s.cfg.holdoff);
            OFS_STATUS: v = {5'h00, s.fsm, s.accepted};
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction
    function automatic logic addr_ok(input logic [7:0] a);
        return (a <= OFS_CMD) && (a[1:0] == 2'h0);
    endfunction
    always_comb begin
        st_nxt = st_r;
        st_nxt.start = 1'b0;
        st_nxt.idle_ret = 1'b0;
        st_nxt.btn_prev = manual_btn_i;
        // apb: one wait state; a write lands only at the edge that samples pready high
        wr_acc = psel_i && penable_i && pwrite_i && st_r.pready;
        rd_acc = psel_i && penable_i && !pwrite_i && !st_r.pready;
        st_nxt.pready = psel_i && penable_i && !st_r.pready;
        st_nxt.pslverr = psel_i && penable_i && !st_r.pready && !addr_ok(paddr_i);
        if (rd_acc) begin
            st_nxt.prdata = rd_mux(st_r, paddr_i);
        end
        if (wr_acc) begin
            case (paddr_i)
                OFS_CTRL: begin
                    st_nxt.cfg.cont = pwdata_i[CB_CONT];
                    st_nxt.cfg.min_width_filter_on = pwdata_i[CB_MINON];
                    st_nxt.cfg.max_width_filter_on = pwdata_i[CB_MAXON];
                    st_nxt.cfg.holdoff_on = pwdata_i[CB_HOLDON];
                    st_nxt.cfg.slope = tqb_slope_type'(pwdata_i[CB_SLOPE +: 2]);
                    st_nxt.cfg.src = tqb_src_type'(pwdata_i[CB_SRC +: 2]);
                end
                OFS_BURST: begin
                    if (pwdata_i[BURST_W-1:0] != '0 && pwdata_i[BURST_W-1:0] <= BURST_MAX) begin
                        st_nxt.cfg.burst = pwdata_i[BURST_W-1:0];
                    end
                end
                OFS_DELAY: begin
                    // out-of-range delay refused; low bits kept as written, software keeps x4
                    if (pwdata_i[DELAY_W-1:0] <= DELAY_MAX && pwdata_i[31:DELAY_W] == '0) begin
                        st_nxt.cfg.delay = pwdata_i[DELAY_W-1:0];
                    end
                end
                OFS_MINW: st_nxt.cfg.min_pulse_width = tqb_sat_cnt(pwdata_i);
                OFS_MAXW: st_nxt.cfg.max_pulse_width = tqb_sat_cnt(pwdata_i);
                OFS_HOLD: st_nxt.cfg.holdoff = tqb_sat_cnt(pwdata_i);
                default: ;
            endcase
        end
        st_nxt.bus_trig = wr_acc && paddr_i == OFS_CMD && pwdata_i[CMD_TRIG];
        // line source also takes the manual button; bus and manual bypass the width filters
        case (st_r.cfg.src)
            SRC_EXT: trig_evt = ext_pass || (manual_btn_i && !st_r.btn_prev);
            SRC_BUS: trig_evt = st_r.bus_trig;
            SRC_MANUAL: trig_evt = manual_btn_i && !st_r.btn_prev;
            default: trig_evt = 1'b0;
        endcase
        case (st_r.fsm)
            ST_IDLE: begin
                // continuous mode ignores burst and delay entirely
                if (!st_r.cfg.cont && trig_evt) begin
                    st_nxt.accepted = st_r.accepted + BURST_W'(1);
                    st_nxt.bcnt = st_r.cfg.burst;
                    if (st_r.cfg.delay == '0) begin
                        st_nxt.fsm = ST_BURST;
                        st_nxt.start = 1'b1;
                    end else begin
                        st_nxt.dcnt = st_r.cfg.delay;
                        st_nxt.fsm = ST_DELAY;
                    end
                end
            end
            ST_DELAY: begin
                // triggers in this state are dropped
                if (st_r.dcnt == DELAY_W'(1)) begin
                    st_nxt.fsm = ST_BURST;
                    st_nxt.start = 1'b1;
                end
                st_nxt.dcnt = st_r.dcnt - DELAY_W'(1);
            end
            ST_BURST: begin
                if (cycle_done_i) begin
                    st_nxt.bcnt = st_r.bcnt - BURST_W'(1);
                    if (st_r.bcnt == BURST_W'(1)) begin
                        st_nxt.fsm = ST_IDLE;
                        st_nxt.idle_ret = 1'b1;
                    end
                end
            end
            default: st_nxt.fsm = ST_IDLE;
        endcase
        if (st_r.cfg.cont && st_r.fsm != ST_IDLE) begin
            st_nxt.fsm = ST_IDLE;
            st_nxt.idle_ret = 1'b1;
        end
        // registered copy so the output comes straight from a flop
        st_nxt.running = (st_nxt.fsm == ST_BURST);
        if (!rst_n_i) begin
            st_nxt = '0;
            st_nxt.fsm = ST_IDLE;
            st_nxt.cfg.cont = CTRL_RST[CB_CONT];
            st_nxt.cfg.burst = BURST_DEF;
            st_nxt.cfg.min_pulse_width = CNT_W'(MIN_W_DEF_CYC);
            st_nxt.cfg.max_pulse_width = CNT_W'(MAX_W_DEF_CYC);
            st_nxt.cfg.holdoff = CNT_W'(HOLD_DEF_CYC);
        end
    end
    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end
    assign prdata_o = st_r.prdata;
    assign pready_o = st_r.pready;
    assign pslverr_o = st_r.pslverr;
    assign burst_start_o = st_r.start;
    assign running_o = st_r.running;
    assign idle_return_o = st_r.idle_ret;

    chk_cont_stays_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_r.cfg.cont && st_r.fsm == ST_IDLE |=> st_r.fsm == ST_IDLE)
        else $error("burst left idle in continuous mode");
    chk_zero_delay_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_r.fsm == ST_IDLE && !st_r.cfg.cont && trig_evt && st_r.cfg.delay == '0
        |=> burst_start_o && running_o)
        else $error("zero delay did not start burst at once");
    chk_delay_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_r.fsm == ST_DELAY && st_r.dcnt == DELAY_W'(1) && !st_r.cfg.cont
        |=> burst_start_o ##1 !burst_start_o)
        else $error("delay end did not start burst");
    chk_burst_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        running_o && cycle_done_i && st_r.bcnt == BURST_W'(1) && !st_r.cfg.cont
        |=> idle_return_o && !running_o)
        else $error("burst did not end after last cycle");
    chk_no_early_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        running_o && !cycle_done_i && !st_r.cfg.cont |=> running_o)
        else $error("burst ended without a finished cycle");
    chk_busy_ignore: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_r.fsm != ST_IDLE |=> st_r.accepted == $past(st_r.accepted))
        else $error("trigger taken while busy");
    chk_start_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        burst_start_o |-> $past(st_r.fsm) != ST_BURST)
        else $error("start pulse inside a burst");
    chk_apb_ready: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
        else $error("apb answer not one cycle");
endmodule // tqb_top
`default_nettype wire

// [bench/tqb_far_model.sv]
// far side model: trigger line, push button and playback cycle timing
`timescale 1ns/1ns
`default_nettype none
module tqb_far_model #(
    parameter int CYC_LEN = 4
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic running_i,
    output logic      trig_o,
    output logic      btn_o,
    output logic      cycle_done_o
);
    int cnt;
    initial begin
        trig_o = 1'b0;
        btn_o = 1'b0;
        cycle_done_o = 1'b0;
        cnt = 0;
    end
    // line or button held high for w clocks; both idle low between pulses
    task automatic pulse(input int w, input bit button);
        @(posedge clk_i);
        if (button)
            btn_o <= 1'b1;
        else
            trig_o <= 1'b1;
        repeat (w) @(posedge clk_i);
        btn_o <= 1'b0;
        trig_o <= 1'b0;
    endtask
    // playback: one finished waveform every CYC_LEN clocks while running
    always @(posedge clk_i) begin
        cycle_done_o <= 1'b0;
        if (!rst_n_i || !running_i)
            cnt <= 0;
        else if (cnt == CYC_LEN - 1) begin
            cnt <= 0;
            cycle_done_o <= 1'b1;
        end else
            cnt <= cnt + 1;
    end
endmodule // tqb_far_model
`default_nettype wire

// [bench/tb_trigger_qualifier_burst.sv]
// testbench: registers, trigger sources, width filters, holdoff, bursts
`timescale 1ns/1ns
`default_nettype none
module tb_trigger_qualifier_burst;
    import tqb_pkg::*;
    logic        clk_i     = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [7:0]  paddr_i   = 8'h00;
    logic [31:0] pwdata_i  = 32'h0000_0000;
    logic [31:0] prdata_o;
    logic        pready_o, pslverr_o, trig_in_i, manual_btn_i, cycle_done_i;
    logic        burst_start_o, running_o, idle_return_o;
    int          num_errors = 0, cmp_count = 0;
    int          n_start = 0, n_done = 0, n_idle = 0, cyc = 0, t_start = 0;

    tqb_top tqb_top_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .trig_in_i(trig_in_i), .manual_btn_i(manual_btn_i),
        .cycle_done_i(cycle_done_i), .burst_start_o(burst_start_o),
        .running_o(running_o), .idle_return_o(idle_return_o));
    tqb_far_model #(.CYC_LEN(4)) tqb_far_model_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .running_i(running_o),
        .trig_o(trig_in_i), .btn_o(manual_btn_i), .cycle_done_o(cycle_done_i));

    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (burst_start_o === 1'b1) begin
            n_start++;
            t_start = cyc;
        end
        if (idle_return_o === 1'b1)
            n_idle++;
        if (cycle_done_i === 1'b1 && running_o === 1'b1)
            n_done++;
    end

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // request held until pready is sampled high; no fixed wait assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        chk("pready seen", 32'h0000_0001, {31'h0, pready_o});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(nm, exp, q);
    endtask
    // one stimulus pulse, then enough clocks for a short burst to end
    task automatic fire(input string nm, input int w, input bit b, input int exp);
        int s0;
        s0 = n_start;
        tqb_far_model_inst.pulse(w, b);
        repeat (40) @(posedge clk_i);
        chk(nm, 32'(s0 + exp), 32'(n_start));
    endtask

    task automatic t_reset;
        logic [31:0] q;
        logic        e;
        rd_chk("ctrl", OFS_CTRL, 32'h0000_0001);
        rd_chk("burst", OFS_BURST, 32'h0000_0001);
        rd_chk("delay", OFS_DELAY, 32'h0000_0000);
        rd_chk("minw", OFS_MINW, 32'h0026_25a0);
        rd_chk("maxw", OFS_MAXW, 32'h0000_61a8);
        rd_chk("holdoff", OFS_HOLD, 32'h0000_0001);
        apb(1'b0, 8'h20, 32'h0000_0000, q, e);
        chk("unmapped err", 32'h0000_0001, {31'h0, e});
        fire("continuous ignores", 2, 1'b0, 0);
        $display("test reset done");
    endtask
    task automatic t_burst;
        int          s, d, i;
        logic [31:0] q0, q1;
        logic        e;
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_BURST, 32'h0000_0003);
        apb(1'b0, OFS_STATUS, 32'h0000_0000, q0, e);
        s = n_start;
        d = n_done;
        i = n_idle;
        tqb_far_model_inst.pulse(2, 1'b0);
        tqb_far_model_inst.pulse(2, 1'b0);
        repeat (40) @(posedge clk_i);
        apb(1'b0, OFS_STATUS, 32'h0000_0000, q1, e);
        chk("starts", 32'(s + 1), 32'(n_start));
        chk("cycles", 32'(d + 3), 32'(n_done));
        chk("idle returns", 32'(i + 1), 32'(n_idle));
        chk("accepted", (q0 & 32'h01ff_ffff) + 1, q1 & 32'h01ff_ffff);
        $display("test burst done");
    endtask
    task automatic t_delay;
        int t0, l0;
        wr(OFS_BURST, 32'h0000_0001);
        t0 = cyc;
        fire("delay zero", 2, 1'b0, 1);
        l0 = t_start - t0;
        wr(OFS_DELAY, 32'h0000_0008);
        t0 = cyc;
        fire("delay eight", 2, 1'b0, 1);
        chk("delay latency", 32'(l0 + 8), 32'(t_start - t0));
        wr(OFS_DELAY, 32'h007a_1201);
        rd_chk("delay over", OFS_DELAY, 32'h0000_0008);
        wr(OFS_DELAY, 32'h007a_1200);
        rd_chk("delay max", OFS_DELAY, 32'h007a_1200);
        wr(OFS_DELAY, 32'h0000_0000);
        wr(OFS_BURST, 32'h0000_0000);
        rd_chk("burst zero", OFS_BURST, 32'h0000_0001);
        wr(OFS_BURST, 32'h0100_0000);
        rd_chk("burst max", OFS_BURST, 32'h0100_0000);
        wr(OFS_BURST, 32'h0000_0001);
        $display("test delay done");
    endtask
    task automatic t_sources;
        bit [2:0] ext_ok = 3'b001;
        bit [2:0] btn_ok = 3'b101;
        bit [2:0] bus_ok = 3'b010;
        int       n0;
        for (int s = 0; s < 3; s++) begin
            wr(OFS_CTRL, 32'(s) << 6);
            fire("source line", 2, 1'b0, ext_ok[s]);
            fire("source button", 2, 1'b1, btn_ok[s]);
            n0 = n_start;
            wr(OFS_CMD, 32'h0000_0001);
            repeat (40) @(posedge clk_i);
            chk("source command", 32'(n0 + bus_ok[s]), 32'(n_start));
        end
        $display("test sources done");
    endtask
    // min only, max only, then window; widths on both sides of each bound
    task automatic t_filters;
        int fc[8] = '{2, 2, 4, 4, 6, 6, 6, 6};
        int mn[8] = '{5, 5, 5, 5, 3, 3, 3, 3};
        int mx[8] = '{9, 9, 5, 5, 6, 6, 6, 6};
        int fw[8] = '{5, 6, 5, 4, 3, 4, 6, 5};
        int fe[8] = '{0, 1, 0, 1, 0, 1, 0, 1};
        for (int k = 0; k < 8; k++) begin
            wr(OFS_CTRL, 32'(fc[k]));
            wr(OFS_MINW, 32'(mn[k]));
            wr(OFS_MAXW, 32'(mx[k]));
            fire("width filter", fw[k], 1'b0, fe[k]);
        end
        $display("test filters done");
    endtask
    task automatic t_holdoff;
        wr(OFS_CTRL, 32'h0000_0008);
        wr(OFS_HOLD, 32'h0000_00c8);
        fire("holdoff first", 2, 1'b0, 1);
        fire("holdoff inside", 2, 1'b0, 0);
        repeat (150) @(posedge clk_i);
        fire("holdoff after", 2, 1'b0, 1);
        $display("test holdoff done");
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_burst();
        t_delay();
        t_sources();
        t_filters();
        t_holdoff();
        give_verdict();
    end
    // whole run needs about 1500 clocks; allow 10000
    initial begin
        #400000;
        num_errors++;
        give_verdict();
    end
endmodule // tb_trigger_qualifier_burst
`default_nettype wire
